/* aors_pkg.sv */
// package for the overload and special-mode register slice
// assumes a 32-bit axi4-lite master; register index times four is the byte address
package aors_pkg;
    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_LOW_RATE_TEST_A = 8'h4A;
    localparam logic [7:0] IDX_LOW_RATE_TEST_B = 8'h62;
    localparam logic [7:0] IDX_LOW_RATE_TEST_D = 8'h7A;
    localparam logic [7:0] IDX_LOW_RATE_TEST_C = 8'h92;
    localparam logic [7:0] IDX_OFFSET_FIX_HELPER = 8'hCF;
    localparam logic [7:0] IDX_TUNING_ONE = 8'hD4;
    localparam logic [7:0] IDX_TUNING_TWO = 8'hD5;
    localparam logic [7:0] IDX_TUNING_THREE = 8'hD6;
    localparam logic [7:0] IDX_TUNING_FOUR_FIVE = 8'hD7;
    localparam logic [7:0] IDX_TUNING_SIX_SEVEN = 8'hDB;
    localparam logic [7:0] IDX_TUNING_EIGHT_TO_TEN = 8'hF0;
    localparam logic [7:0] IDX_TUNING_ELEVEN_SWING = 8'hF1;
    localparam logic [7:0] IDX_TUNING_TWELVE_THIRTEEN = 8'hF5;
    localparam logic [7:0] IDX_OVERLOAD_THRESHOLD_LEVEL = 8'hC3;
    localparam logic [7:0] IDX_OVERLOAD_THRESHOLD_OVERRIDE = 8'hC4;
    localparam logic [7:0] IDX_OVERLOAD_SELECT = 8'h45;
    localparam logic [7:0] IDX_OVERLOAD_STATUS = 8'hE0;
    // ------------------------------------------------------------
    // writable bit masks, field positions and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_LOW_RATE = 8'h01;
    localparam logic [7:0] MASK_HELPER = 8'h08;
    localparam logic [7:0] MASK_BIT7 = 8'h80;
    localparam logic [7:0] MASK_FOUR_FIVE = 8'h0C;
    localparam logic [7:0] MASK_SIX_SEVEN = 8'h30;
    localparam logic [7:0] MASK_EIGHT_TEN = 8'h38;
    localparam logic [7:0] MASK_ELEVEN_SWING = 8'h23;
    localparam logic [7:0] MASK_TWELVE_THIRTEEN = 8'h42;
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam logic [7:0] MASK_SELECT = 8'h08;
    localparam int OVERRIDE_EN_BIT = 7;
    localparam int SELECT_BIT = 3;
    localparam int HELPER_BIT = 3;
    localparam logic [1:0] SWING_ON = 2'h3;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] TRIP_CODE_DEFAULT = 8'hE6; // decimal 230
    localparam logic [19:0] TRIP_DIVISOR = 20'h000FF; // decimal 255
    // ------------------------------------------------------------
    // latencies in output clock cycles and bus answers
    // ------------------------------------------------------------
    localparam int QUICK_LATENCY = 7;
    localparam int NORMAL_LATENCY = 10;
    localparam int NSLOT = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // configuration handed to the converter core
    typedef struct packed {
        logic [12:0] tuning_bits;
        logic output_swing_ctrl_enable;
        logic low_rate_mode;
        logic offset_fix_helper_bit;
        logic overload_flavour_select;
        logic [7:0] overload_trip_code;
    } aors_cfg_t;
endpackage

/* aors_regs.sv */
// overload detector plus special-mode register slice behind an axi4-lite slave
// assumes channel levels are unsigned magnitudes synchronous to aclk
// Function
// - flag input level above programmable threshold
// - quick flag asserts seven cycles later
// - programmed code used only when override set
// - trip level is fullscale times code/255
// - threshold code is bits 7..0
// - unwritten enabled threshold defaults to 230
// - override enable sits in bit 7
// - swing control on at 11, off at 00
// - all four low-rate bits enable slow clocks
// - all registers reset to 00h
// - select bit zero picks quick overload flag
`timescale 1ns/1ps
module aors_regs #(
    parameter int NCH = 4,
    parameter int LEVEL_W = 11,
    parameter logic [LEVEL_W-1:0] FULL_SCALE = '1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NCH*LEVEL_W-1:0] ch_level,
    output logic [NCH-1:0] quick_overload_flag,
    output logic [NCH-1:0] overload_flag,
    output aors_pkg::aors_cfg_t cfg
);
    import aors_pkg::*;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // index to storage slot; NSLOT means unmapped
    function automatic logic [4:0] slot_of(input logic [7:0] idx);
        case (idx)
            IDX_LOW_RATE_TEST_A: slot_of = 5'h00;
            IDX_LOW_RATE_TEST_B: slot_of = 5'h01;
            IDX_LOW_RATE_TEST_D: slot_of = 5'h02;
            IDX_LOW_RATE_TEST_C: slot_of = 5'h03;
            IDX_OFFSET_FIX_HELPER: slot_of = 5'h04;
            IDX_TUNING_ONE: slot_of = 5'h05;
            IDX_TUNING_TWO: slot_of = 5'h06;
            IDX_TUNING_THREE: slot_of = 5'h07;
            IDX_TUNING_FOUR_FIVE: slot_of = 5'h08;
            IDX_TUNING_SIX_SEVEN: slot_of = 5'h09;
            IDX_TUNING_EIGHT_TO_TEN: slot_of = 5'h0A;
            IDX_TUNING_ELEVEN_SWING: slot_of = 5'h0B;
            IDX_TUNING_TWELVE_THIRTEEN: slot_of = 5'h0C;
            IDX_OVERLOAD_THRESHOLD_LEVEL: slot_of = 5'h0D;
            IDX_OVERLOAD_THRESHOLD_OVERRIDE: slot_of = 5'h0E;
            IDX_OVERLOAD_SELECT: slot_of = 5'h0F;
            default: slot_of = 5'h10;
        endcase
    endfunction

    // bits that exist in each slot; the rest read zero and ignore writes
    function automatic logic [7:0] mask_of(input logic [4:0] slot);
        case (slot)
            5'h00, 5'h01, 5'h02, 5'h03: mask_of = MASK_LOW_RATE;
            5'h04: mask_of = MASK_HELPER;
            5'h05, 5'h06, 5'h07, 5'h0E: mask_of = MASK_BIT7;
            5'h08: mask_of = MASK_FOUR_FIVE;
            5'h09: mask_of = MASK_SIX_SEVEN;
            5'h0A: mask_of = MASK_EIGHT_TEN;
            5'h0B: mask_of = MASK_ELEVEN_SWING;
            5'h0C: mask_of = MASK_TWELVE_THIRTEEN;
            5'h0D: mask_of = MASK_FULL;
            5'h0F: mask_of = MASK_SELECT;
            default: mask_of = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // bus and register state
    // ------------------------------------------------------------
    logic [7:0] regs_reg [NSLOT];
    logic [7:0] regs_next [NSLOT];
    logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [7:0] aw_idx_reg, aw_idx_next;
    logic [7:0] w_data_reg, w_data_next;
    logic w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic trip_written_reg, trip_written_next;
    logic [4:0] wslot, rslot;
    logic do_write;

    // one write and one read in flight; new address waits for the response
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign wslot = slot_of(aw_idx_reg);
    assign rslot = slot_of(s_axi_araddr[9:2]);
    assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;

    // next state of the bus slave and register file
    always_comb
    begin
        aw_hold_next = aw_hold_reg;
        w_hold_next = w_hold_reg;
        aw_idx_next = aw_idx_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        trip_written_next = trip_written_reg;
        for (int i = 0; i < NSLOT; i++)
        begin
            regs_next[i] = regs_reg[i];
        end
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_next = 1'b1;
            aw_idx_next = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_next = 1'b1;
            w_data_next = s_axi_wdata[7:0];
            w_strb_next = s_axi_wstrb[0];
        end
        if (do_write)
        begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (wslot == 5'h10) ? RESP_SLVERR : RESP_OKAY;
            if (wslot != 5'h10 && w_strb_reg)
            begin
                regs_next[wslot[3:0]] = w_data_reg & mask_of(wslot);
                // first write ends the default code
                if (wslot == 5'h0D)
                begin
                    trip_written_next = 1'b1;
                end
            end
        end
        else if (bvalid_reg && s_axi_bready)
        begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = 32'h0000_0000;
            if (s_axi_araddr[9:2] == IDX_OVERLOAD_STATUS)
            begin
                rdata_next[2*NCH-1:0] = {overload_flag, quick_overload_flag};
            end
            else if (rslot == 5'h10)
            begin
                rresp_next = RESP_SLVERR;
            end
            else
            begin
                rdata_next[7:0] = regs_reg[rslot[3:0]];
            end
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_next = 1'b0;
        end
    end

    // registers only; reset is synchronous
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_idx_reg <= 8'h00;
            w_data_reg <= 8'h00;
            w_strb_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
            trip_written_reg <= 1'b0;
            for (int i = 0; i < NSLOT; i++)
            begin
                regs_reg[i] <= REG_RESET;
            end
        end
        else
        begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            aw_idx_reg <= aw_idx_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            trip_written_reg <= trip_written_next;
            for (int i = 0; i < NSLOT; i++)
            begin
                regs_reg[i] <= regs_next[i];
            end
        end
    end

    // ------------------------------------------------------------
    // configuration outputs
    // ------------------------------------------------------------
    aors_cfg_t cfg_reg, cfg_next;
    logic [7:0] trip_code;

    // enable is bit 7 of override
    assign trip_code = (regs_reg[14][OVERRIDE_EN_BIT] && trip_written_reg)
        ? regs_reg[13] : TRIP_CODE_DEFAULT;

    // one-cycle registered copy so data outputs come from flops
    always_comb
    begin
        cfg_next.overload_trip_code = trip_code;
        cfg_next.overload_flavour_select = regs_reg[15][SELECT_BIT];
        cfg_next.offset_fix_helper_bit = regs_reg[4][HELPER_BIT];
        cfg_next.low_rate_mode = regs_reg[0][0] & regs_reg[1][0] & regs_reg[2][0]
            & regs_reg[3][0];
        cfg_next.output_swing_ctrl_enable = (regs_reg[11][1:0] == SWING_ON);
        cfg_next.tuning_bits = {regs_reg[12][6], regs_reg[12][1], regs_reg[11][5],
            regs_reg[10][5:3], regs_reg[9][5:4], regs_reg[8][3:2], regs_reg[7][7],
            regs_reg[6][7], regs_reg[5][7]};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_reg <= '0;
        end
        else
        begin
            cfg_reg <= cfg_next;
        end
    end
    assign cfg = cfg_reg;

    // ------------------------------------------------------------
    // overload detection per channel
    // ------------------------------------------------------------
    logic [NCH-1:0] quick_pipe_reg [QUICK_LATENCY];
    logic [NCH-1:0] quick_pipe_next [QUICK_LATENCY];
    logic [NCH-1:0] normal_pipe_reg [NORMAL_LATENCY];
    logic [NCH-1:0] normal_pipe_next [NORMAL_LATENCY];
    logic [NCH-1:0] above_trip, at_full;

    // compare level*255 against fullscale*code, no divider
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_cmp
            logic [19:0] lvl_scaled, trip_scaled;
            assign lvl_scaled = 20'(ch_level[g*LEVEL_W +: LEVEL_W]) * TRIP_DIVISOR;
            assign trip_scaled = 20'(FULL_SCALE) * 20'(trip_code);
            assign above_trip[g] = lvl_scaled > trip_scaled;
            assign at_full[g] = ch_level[g*LEVEL_W +: LEVEL_W] >= FULL_SCALE;
        end
    endgenerate

    // seven-stage delay to the quick flag
    always_comb
    begin
        quick_pipe_next[0] = above_trip;
        for (int i = 1; i < QUICK_LATENCY; i++)
        begin
            quick_pipe_next[i] = quick_pipe_reg[i-1];
        end
        normal_pipe_next[0] = at_full;
        for (int i = 1; i < NORMAL_LATENCY; i++)
        begin
            normal_pipe_next[i] = normal_pipe_reg[i-1];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < QUICK_LATENCY; i++)
            begin
                quick_pipe_reg[i] <= '0;
            end
            for (int i = 0; i < NORMAL_LATENCY; i++)
            begin
                normal_pipe_reg[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < QUICK_LATENCY; i++)
            begin
                quick_pipe_reg[i] <= quick_pipe_next[i];
            end
            for (int i = 0; i < NORMAL_LATENCY; i++)
            begin
                normal_pipe_reg[i] <= normal_pipe_next[i];
            end
        end
    end

    assign quick_overload_flag = quick_pipe_reg[QUICK_LATENCY-1];
    assign overload_flag = cfg_reg.overload_flavour_select
        ? normal_pipe_reg[NORMAL_LATENCY-1] : quick_pipe_reg[QUICK_LATENCY-1];

    // ------------------------------------------------------------
    // assertions and covers
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_quick_latency: assert property ($past(aresetn, 7) |->
        quick_overload_flag == $past(above_trip, 7)) else $error("quick flag latency wrong");
    a_flag_drops: assert property ((above_trip == '0) ##1 (above_trip == '0) [*6]
        |=> quick_overload_flag == '0) else $error("flag stuck after level fell");
    a_default_code: assert property (!trip_written_reg |->
        trip_code == TRIP_CODE_DEFAULT) else $error("default trip code not 230");
    a_override_gate: assert property (!regs_reg[14][OVERRIDE_EN_BIT] |->
        trip_code == TRIP_CODE_DEFAULT) else $error("code used without override");
    a_swing_code: assert property (regs_reg[11][1:0] == 2'h0 |=>
        !cfg.output_swing_ctrl_enable) else $error("swing enabled at code 00");
    a_low_rate_all: assert property (cfg.low_rate_mode |->
        $past(regs_reg[0][0] & regs_reg[1][0] & regs_reg[2][0] & regs_reg[3][0]))
        else $error("low rate without all bits");
    a_reset_zero: assert property ($past(!aresetn) |->
        regs_reg[13] == REG_RESET && regs_reg[14] == REG_RESET) else $error("reset not 00h");
    a_select_quick: assert property (!cfg.overload_flavour_select |->
        overload_flag == quick_overload_flag) else $error("select zero not quick");
    a_write_resp: assert property (do_write |=> s_axi_bvalid)
        else $error("write without response");
    a_mask_held: assert property (do_write && wslot == 5'h0E |=>
        (regs_reg[14] & ~MASK_BIT7) == 8'h00) else $error("reserved bit stored");

    c_trip_write: cover property (do_write && wslot == 5'h0D);
    c_quick_rise: cover property ($rose(quick_overload_flag[0]));
    c_status_read: cover property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[9:2] == IDX_OVERLOAD_STATUS);
endmodule

/* tb.sv */
// self-checking bench for the overload detector and special-mode register slice
// assumes aors_regs with default parameters: four channels, 11-bit levels, full scale 2047
`timescale 1ns/1ps
module tb;
    import aors_pkg::*;
    // ------------------------------------------------------------
    // signals and bench state
    // ------------------------------------------------------------
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, mon, sel;
    logic [9:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb, qf, of;
    logic [1:0] bresp, rresp, r;
    logic [43:0] lvl;
    aors_cfg_t cfg;
    int miscompares, comparisons, cnt, trip, nq;
    logic [3:0] hq[4096];
    logic [3:0] hn[4096];
    logic [7:0] idx_t[16] = '{8'h4A, 8'h62, 8'h7A, 8'h92, 8'hCF, 8'hD4, 8'hD5, 8'hD6,
        8'hD7, 8'hDB, 8'hF0, 8'hF1, 8'hF5, 8'hC3, 8'hC4, 8'h45};
    logic [7:0] msk_t[16] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h08, 8'h80, 8'h80, 8'h80,
        8'h0C, 8'h30, 8'h38, 8'h23, 8'h42, 8'hFF, 8'h80, 8'h08};

    aors_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ch_level(lvl), .quick_overload_flag(qf),
        .overload_flag(of), .cfg(cfg));

    // 40 ns period
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            comparisons++;
            if (seen !== exp)
            begin
                miscompares++;
                $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    task automatic end_sim;
        begin
            $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
            if (miscompares == 0 && comparisons > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    // a hung handshake counts as a mismatch
    task automatic hang(input int n);
        begin
            if (n >= 50)
            begin
                miscompares++;
                end_sim();
            end
        end
    endtask
    // ------------------------------------------------------------
    // axi4-lite master, entered just after a rising edge
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] idx, input logic [7:0] v, input logic [3:0] st,
        output logic [1:0] rs);
        int n;
        begin
            n = 0;
            awaddr <= {idx, 2'b00};
            wdata <= {24'h0, v};
            wstrb <= st;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do
            begin
                @(posedge aclk);
                n++;
                if (awvalid && awready)
                    awvalid <= 1'b0;
                if (wvalid && wready)
                    wvalid <= 1'b0;
                rs = bresp;
            end while (!bvalid && n < 50);
            // bready stays high between writes so no edge sees it toggled twice
            hang(n);
        end
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] dv, output logic [1:0] rs);
        int n;
        begin
            n = 0;
            araddr <= {idx, 2'b00};
            arvalid <= 1'b1;
            rready <= 1'b1;
            do
            begin
                @(posedge aclk);
                n++;
                if (arvalid && arready)
                    arvalid <= 1'b0;
                dv = rdata;
                rs = rresp;
            end while (!rvalid && n < 50);
            // rready stays high between reads so no edge sees it toggled twice
            hang(n);
        end
    endtask
    // ------------------------------------------------------------
    // detector model: pure compare delayed by the flag latency
    // ------------------------------------------------------------
    function automatic logic [3:0] mq(input logic [43:0] lv, input int code);
        logic [3:0] f;
        for (int g = 0; g < 4; g++)
            f[g] = (int'(lv[g*11 +: 11]) * 255) > (2047 * code);
        return f;
    endfunction

    function automatic logic [3:0] mn(input logic [43:0] lv);
        logic [3:0] f;
        for (int g = 0; g < 4; g++)
            f[g] = lv[g*11 +: 11] == 11'h7FF;
        return f;
    endfunction

    // levels cluster on full scale and on both sides of the trip point
    function automatic logic [10:0] pick(input int code);
        int b;
        b = (2047 * code) / 255;
        case ($urandom % 4)
            0: return 11'h7FF;
            1: return b[10:0];
            2: return b[10:0] + 11'h1;
            default: return 11'($urandom % 2048);
        endcase
    endfunction

    // record what each edge samples
    always @(posedge aclk)
    begin
        if (mon)
        begin
            hq[cnt] = mq(lvl, trip);
            hn[cnt] = mn(lvl);
            cnt = cnt + 1;
        end
    end

    // flags compared mid-cycle, well clear of the edge updates
    always @(negedge aclk)
    begin
        if (mon && cnt >= 11)
        begin
            // a level sampled at one edge shows on the flag six edges later
            chk({28'h0, qf}, {28'h0, hq[cnt-7]});
            chk({28'h0, of}, {28'h0, sel ? hn[cnt-10] : hq[cnt-7]});
        end
    end

    // watchdog on the whole run
    initial
    begin
        repeat (100000) @(posedge aclk);
        miscompares++;
        end_sim();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, mon, sel} = '0;
        {awaddr, araddr, wdata, wstrb, lvl} = '0;
        miscompares = 0;
        comparisons = 0;
        cnt = 0;
        trip = 230;
        void'($urandom(13));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 16; i++)
        begin
            rd(idx_t[i], d, r);
            chk(d, 32'h0);
        end
        chk({24'h0, cfg.overload_trip_code}, 32'hE6);
        wr(8'hC4, 8'h80, 4'h1, r);
        repeat (2) @(posedge aclk);
        chk({24'h0, cfg.overload_trip_code}, 32'hE6);
        // assigned bits set, unassigned written zero
        for (int i = 0; i < 16; i++)
        begin
            wr(idx_t[i], msk_t[i], 4'h1, r);
            rd(idx_t[i], d, r);
            chk(d, {24'h0, msk_t[i]});
        end
        repeat (2) @(posedge aclk);
        chk({7'h0, cfg}, 32'h01FFFFFF);
        for (int i = 0; i < 16; i++)
            wr(idx_t[i], 8'h00, 4'h1, r);
        repeat (2) @(posedge aclk);
        // with override clear the code stays at its default
        chk({7'h0, cfg}, 32'h000000E6);
        // unmapped place and empty strobe
        wr(8'h00, 8'hFF, 4'h1, r);
        chk({30'h0, r}, 32'h2);
        rd(8'h00, d, r);
        chk({30'h0, r}, 32'h2);
        chk(d, 32'h0);
        wr(8'hC3, 8'hFF, 4'h0, r);
        rd(8'hC3, d, r);
        chk(d, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            chk({31'h0, cfg.low_rate_mode}, 32'h0);
            wr(idx_t[i], 8'h01, 4'h1, r);
            repeat (2) @(posedge aclk);
        end
        chk({31'h0, cfg.low_rate_mode}, 32'h1);
        // low-rate bits only for this functional check
        for (int i = 0; i < 4; i++)
            wr(idx_t[i], 8'h00, 4'h1, r);
        // toggle between the two legal swing codes
        for (int c = 0; c < 4; c++)
        begin
            wr(8'hF1, c[0] ? 8'h03 : 8'h00, 4'h1, r);
            repeat (2) @(posedge aclk);
            chk({31'h0, cfg.output_swing_ctrl_enable}, {31'h0, c[0]});
        end
        // default code, programmed code, then normal flavour
        for (int ph = 0; ph < 3; ph++)
        begin
            nq = $urandom_range(254, 1);
            wr(8'hC3, nq[7:0], 4'h1, r);
            wr(8'hC4, (ph > 0) ? 8'h80 : 8'h00, 4'h1, r);
            wr(8'h45, (ph == 2) ? 8'h08 : 8'h00, 4'h1, r);
            trip = (ph > 0) ? nq : 230;
            sel = (ph == 2);
            repeat (4) @(posedge aclk);
            cnt = 0;
            mon = 1'b1;
            repeat (200)
            begin
                @(posedge aclk);
                for (int g = 0; g < 4; g++)
                    lvl[g*11 +: 11] <= pick(trip);
            end
            mon = 1'b0;
        end
        // status view with every channel at full scale
        lvl <= '1;
        repeat (12) @(posedge aclk);
        rd(8'hE0, d, r);
        chk(d, 32'hFF);
        end_sim();
    end
endmodule
